// file: design/arm_ctrl.sv
// Converter digital side: straps, power-down, wake timer, pipeline, output stage, bus
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module arm_ctrl #(
	parameter int WAKE_CYC = arm_pkg::ARM_WAKE_CYC
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [31:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	input wire logic [1:0] MODE_STRAP,
	input wire logic [1:0] REF_GEN_SELECT,
	input wire logic [10:0] SAMPLE_IN,
	input wire logic POWER_DOWN_REQUEST,
	input wire logic OUTPUT_DRIVE_ENABLE_N,
	output logic [9:0] DATA_OUT,
	output logic [9:0] DATA_OE,
	output logic RANGE_EXCEEDED_FLAG,
	output logic RANGE_EXCEEDED_OE,
	output logic RESULT_VALID,
	output logic [5:0] REF_ROUTE,
	output logic [1:0] GEN_OUTPUT
);
	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Clamp a signed offset sample onto the unsigned code range
	function automatic arm_pkg::arm_samp_t arm_clamp(input logic [10:0] raw, input logic live);
		arm_pkg::arm_samp_t s;
		s.live = live;
		if (raw[10] && raw[9]) begin
			s.code = arm_pkg::ARM_CODE_MIN;
			s.over = 1'b1;
		end else if (!raw[10] && raw[9]) begin
			s.code = arm_pkg::ARM_CODE_MAX;
			s.over = 1'b1;
		end else begin
			s.code = {~raw[8], raw[8:0]};
			s.over = 1'b0;
		end
		return s;
	endfunction : arm_clamp

	// ------------------------------------------------------------
	// Power-down and wake timer
	// ------------------------------------------------------------
	logic pd_sw_reg;
	logic pd_eff;
	logic [31:0] wake_cnt_reg;
	logic awake;
	arm_pkg::arm_mode_t mode;
	logic needs_wake;
	assign mode = arm_pkg::arm_mode_t'(MODE_STRAP);
	assign needs_wake = (mode == arm_pkg::ARM_MODE_MID) || (mode == arm_pkg::ARM_MODE_SUP);
	assign pd_eff = POWER_DOWN_REQUEST | pd_sw_reg;
	assign awake = (wake_cnt_reg == 32'h00000000);

	// Wake counter restarts on power-up and every power-down
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			wake_cnt_reg <= 32'(WAKE_CYC);
		end else if (pd_eff) begin
			wake_cnt_reg <= 32'(WAKE_CYC);
		end else if (!needs_wake) begin
			wake_cnt_reg <= 32'h00000000;
		end else if (!awake) begin
			wake_cnt_reg <= wake_cnt_reg - 32'h00000001;
		end
	end

	// ------------------------------------------------------------
	// Conversion pipeline
	// ------------------------------------------------------------
	arm_pkg::arm_samp_t pipe_reg [arm_pkg::ARM_PIPE_DEPTH];
	arm_pkg::arm_samp_t samp_next;
	assign samp_next = arm_clamp(SAMPLE_IN, awake && !pd_eff);

	// Three stages from sample edge to head; the output register makes it four edges to the output word
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			for (int i = 0; i < arm_pkg::ARM_PIPE_DEPTH; i++) begin
				pipe_reg[i] <= '0;
			end
		end else if (pd_eff) begin
			for (int i = 0; i < arm_pkg::ARM_PIPE_DEPTH; i++) begin
				pipe_reg[i] <= '0;
			end
		end else begin
			pipe_reg[0] <= samp_next;
			for (int i = 1; i < arm_pkg::ARM_PIPE_DEPTH; i++) begin
				pipe_reg[i] <= pipe_reg[i-1];
			end
		end
	end

	// ------------------------------------------------------------
	// Output stage
	// ------------------------------------------------------------
	arm_pkg::arm_samp_t head;
	assign head = pipe_reg[arm_pkg::ARM_PIPE_DEPTH-1];

	// Drive data and flag while enabled, release otherwise
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			DATA_OUT <= 10'h000;
			DATA_OE <= 10'h000;
			RANGE_EXCEEDED_FLAG <= 1'b0;
			RANGE_EXCEEDED_OE <= 1'b0;
			RESULT_VALID <= 1'b0;
		end else begin
			DATA_OUT <= head.code;
			DATA_OE <= {10{~OUTPUT_DRIVE_ENABLE_N}};
			RANGE_EXCEEDED_FLAG <= head.over;
			RANGE_EXCEEDED_OE <= ~OUTPUT_DRIVE_ENABLE_N;
			RESULT_VALID <= head.live && !pd_eff;
		end
	end

	// ------------------------------------------------------------
	// Reference routing from straps
	// ------------------------------------------------------------
	arm_pkg::arm_route_t route;
	arm_pkg::arm_genout_t genout;
	arm_pkg::arm_gen_t gsel;
	assign gsel = arm_pkg::arm_gen_t'(REF_GEN_SELECT);

	// Switch settings per mode strap
	always_comb begin
		route = '0;
		case (mode)
			arm_pkg::ARM_MODE_GND: begin
				route.sense_force_tie = 1'b1;
			end
			arm_pkg::ARM_MODE_MID: begin
				route.buf_en = 1'b1;
				route.buf_from_span = 1'b1;
				route.force_driven = 1'b1;
			end
			arm_pkg::ARM_MODE_SUP: begin
				route.buf_en = 1'b1;
				route.buf_from_sense = 1'b1;
				route.force_driven = 1'b1;
			end
			default: begin
				route = '0;
			end
		endcase
		route.gen_en = (gsel != arm_pkg::ARM_GEN_SUP);
	end

	// Generator output per select strap
	always_comb begin
		case (gsel)
			arm_pkg::ARM_GEN_SPAN: genout = arm_pkg::ARM_GEN_OUT_1V;
			arm_pkg::ARM_GEN_GND: genout = arm_pkg::ARM_GEN_OUT_2V;
			arm_pkg::ARM_GEN_DIV: genout = arm_pkg::ARM_GEN_OUT_RATIO;
			default: genout = arm_pkg::ARM_GEN_OUT_OPEN;
		endcase
	end

	// Registered routing outputs
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			REF_ROUTE <= 6'h00;
			GEN_OUTPUT <= 2'h3;
		end else begin
			REF_ROUTE <= route;
			GEN_OUTPUT <= genout;
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	logic req;
	logic [1:0] widx;
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign widx = WB_ADR_I[3:2];

	// One-cycle acknowledge and read mux
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= req;
			if (req && !WB_WE_I) begin
				case (widx)
					arm_pkg::ARM_OFF_CTRL: WB_DAT_O <= {31'h0, pd_sw_reg};
					arm_pkg::ARM_OFF_STAT: WB_DAT_O <= {28'h0, RESULT_VALID, pd_eff,
						awake, RANGE_EXCEEDED_FLAG};
					arm_pkg::ARM_OFF_DATA: WB_DAT_O <= {22'h0, DATA_OUT};
					arm_pkg::ARM_OFF_SAMP: WB_DAT_O <= {20'h0, REF_ROUTE, MODE_STRAP,
						REF_GEN_SELECT, GEN_OUTPUT};
					default: WB_DAT_O <= 32'h00000000;
				endcase
			end
		end
	end

	// Software power-down control bit
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pd_sw_reg <= 1'b0;
		end else if (req && WB_WE_I && WB_SEL_I[0] && widx == arm_pkg::ARM_OFF_CTRL
			&& WB_ADR_I[31:4] == 28'h0) begin
			pd_sw_reg <= WB_DAT_I[arm_pkg::ARM_CTRL_PD];
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	latency_check_a: assert property (@(posedge CLOCK) disable iff (RST)
		(!pd_eff [*5]) |-> (DATA_OUT == $past(samp_next.code, 4)))
		else $error("data latency wrong");
	oe_release_a: assert property (@(posedge CLOCK) disable iff (RST)
		!$past(RST) && $past(OUTPUT_DRIVE_ENABLE_N) |->
		(DATA_OE == 10'h000 && !RANGE_EXCEEDED_OE))
		else $error("outputs not released");
	oe_drive_a: assert property (@(posedge CLOCK) disable iff (RST)
		!$past(RST) && !$past(OUTPUT_DRIVE_ENABLE_N) |->
		(DATA_OE == 10'h3FF && RANGE_EXCEEDED_OE))
		else $error("outputs not driven");
	sat_flag_a: assert property (@(posedge CLOCK) disable iff (RST)
		(!pd_eff [*5]) && $past(samp_next.over, 4) |-> RANGE_EXCEEDED_FLAG)
		else $error("range flag missing");
	sat_code_a: assert property (@(posedge CLOCK) disable iff (RST)
		samp_next.over |-> (samp_next.code == 10'h000 || samp_next.code == 10'h3FF))
		else $error("no saturation");
	pd_invalid_a: assert property (@(posedge CLOCK) disable iff (RST)
		pd_eff |=> !RESULT_VALID [*3])
		else $error("valid during power-down");
	wake_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
		$fell(pd_eff) && needs_wake |-> !awake)
		else $error("wake interval skipped");
	gen_off_a: assert property (@(posedge CLOCK) disable iff (RST)
		(gsel == arm_pkg::ARM_GEN_SUP) |=> (GEN_OUTPUT == 2'h3 || $changed(REF_GEN_SELECT)))
		else $error("generator not off");
	route_gnd_a: assert property (@(posedge CLOCK) disable iff (RST)
		(mode == arm_pkg::ARM_MODE_GND) && $stable(MODE_STRAP) |=> !REF_ROUTE[5] && REF_ROUTE[1])
		else $error("ground mode routing");
	valid_fill_a: assert property (@(posedge CLOCK) disable iff (RST)
		RESULT_VALID |-> $past(awake, 4))
		else $error("valid before fill");

	// ------------------------------------------------------------
	// Bus handshake, routing, power-down, wake and flag checks
	// ------------------------------------------------------------
	// Acknowledge is a single-cycle pulse
	ack_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
		WB_ACK_O
		|=> !WB_ACK_O)
		else $error("ack longer than one cycle");

	// Every taken request is answered on the next edge
	ack_answer_a: assert property (@(posedge CLOCK) disable iff (RST)
		WB_CYC_I && WB_STB_I && !WB_ACK_O
		|=> WB_ACK_O)
		else $error("request not answered");

	// No acknowledge without a request
	ack_idle_a: assert property (@(posedge CLOCK) disable iff (RST)
		!(WB_CYC_I && WB_STB_I)
		|=> !WB_ACK_O)
		else $error("ack without request");

	// Mid-supply strap routes buffer from span input
	mid_route_a: assert property (@(posedge CLOCK) disable iff (RST)
		(mode == arm_pkg::ARM_MODE_MID)
		|=> (REF_ROUTE[5:1] == 5'h1A))
		else $error("mid mode routing");

	// Supply strap routes buffer from sense pins
	sup_route_a: assert property (@(posedge CLOCK) disable iff (RST)
		(mode == arm_pkg::ARM_MODE_SUP)
		|=> (REF_ROUTE[5:1] == 5'h16))
		else $error("supply mode routing");

	// Span strap gives the low generator setting
	gen_low_a: assert property (@(posedge CLOCK) disable iff (RST)
		(gsel == arm_pkg::ARM_GEN_SPAN)
		|=> (GEN_OUTPUT == 2'h0))
		else $error("generator low setting");

	// Ground strap gives the high generator setting
	gen_high_a: assert property (@(posedge CLOCK) disable iff (RST)
		(gsel == arm_pkg::ARM_GEN_GND)
		|=> (GEN_OUTPUT == 2'h1))
		else $error("generator high setting");

	// Divider strap gives the ratio setting
	gen_ratio_a: assert property (@(posedge CLOCK) disable iff (RST)
		(gsel == arm_pkg::ARM_GEN_DIV)
		|=> (GEN_OUTPUT == 2'h2))
		else $error("generator ratio setting");

	// Supply strap switches the generator off
	gen_enable_a: assert property (@(posedge CLOCK) disable iff (RST)
		(gsel == arm_pkg::ARM_GEN_SUP)
		|=> !REF_ROUTE[0])
		else $error("generator left enabled");

	// Power-down empties the first pipeline stage
	pd_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		pd_eff
		|=> (pipe_reg[0] == '0))
		else $error("pipeline not cleared");

	// Power-down reloads the wake timer
	pd_reload_a: assert property (@(posedge CLOCK) disable iff (RST)
		pd_eff
		|=> (wake_cnt_reg == 32'(WAKE_CYC)))
		else $error("wake timer not reloaded");

	// Wake timer counts down one per cycle
	wake_count_a: assert property (@(posedge CLOCK) disable iff (RST)
		needs_wake && !pd_eff && !awake
		|=> (wake_cnt_reg == $past(wake_cnt_reg) - 32'h00000001))
		else $error("wake timer stalled");

	// Ground strap needs no wake interval
	gnd_awake_a: assert property (@(posedge CLOCK) disable iff (RST)
		!needs_wake && !pd_eff
		|=> awake)
		else $error("ground mode not awake");

	// Flag only ever comes with a saturated code
	flag_code_a: assert property (@(posedge CLOCK) disable iff (RST)
		RANGE_EXCEEDED_FLAG
		|-> (DATA_OUT == 10'h000 || DATA_OUT == 10'h3FF))
		else $error("flag without saturated code");

	// In-span samples never raise the flag
	flag_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		(!pd_eff [*5]) && !$past(samp_next.over, 4)
		|-> !RANGE_EXCEEDED_FLAG)
		else $error("flag on in-span sample");

	// Valid never follows a powered-down cycle
	valid_pd_a: assert property (@(posedge CLOCK) disable iff (RST)
		RESULT_VALID
		|-> !$past(pd_eff))
		else $error("valid right after power-down");
endmodule : arm_ctrl

// file: design/arm_pkg.sv
// Constants, types and strap encodings for the converter control block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package arm_pkg;
	localparam int ARM_DATA_W = 10;
	localparam logic [9:0] ARM_CODE_MIN = 10'h000;
	localparam logic [9:0] ARM_CODE_MAX = 10'h3FF;
	localparam int ARM_PIPE_DEPTH = 3;
	localparam int ARM_CLK_MHZ = 100;
	localparam int ARM_WAKE_MS = 5;
	localparam int ARM_WAKE_CYC = ARM_WAKE_MS * 1000 * 1000 / 10;
	localparam logic [1:0] ARM_OFF_CTRL = 2'h0;
	localparam logic [1:0] ARM_OFF_STAT = 2'h1;
	localparam logic [1:0] ARM_OFF_DATA = 2'h2;
	localparam logic [1:0] ARM_OFF_SAMP = 2'h3;
	localparam int ARM_CTRL_PD = 0;

	// Reference mode strap levels
	typedef enum logic [1:0] {
		ARM_MODE_GND = 2'b00,
		ARM_MODE_MID = 2'b01,
		ARM_MODE_SUP = 2'b10
	} arm_mode_t;

	// Reference generator select strap levels
	typedef enum logic [1:0] {
		ARM_GEN_SPAN = 2'b00,
		ARM_GEN_GND = 2'b01,
		ARM_GEN_DIV = 2'b10,
		ARM_GEN_SUP = 2'b11
	} arm_gen_t;

	typedef enum logic [1:0] {
		ARM_GEN_OUT_1V = 2'b00,
		ARM_GEN_OUT_2V = 2'b01,
		ARM_GEN_OUT_RATIO = 2'b10,
		ARM_GEN_OUT_OPEN = 2'b11
	} arm_genout_t;

	// Sample entering the pipeline
	typedef struct packed {
		logic [9:0] code;
		logic over;
		logic live;
	} arm_samp_t;

	// Reference routing switches
	typedef struct packed {
		logic buf_en;
		logic buf_from_span;
		logic buf_from_sense;
		logic force_driven;
		logic sense_force_tie;
		logic gen_en;
	} arm_route_t;
endpackage : arm_pkg

// file: dv/arm_host_cap.sv
// Host model that resolves the output pins and captures genuine words
`timescale 1ns/10ps
module arm_host_cap (
	input wire logic clk,
	input wire logic [9:0] data_out,
	input wire logic [9:0] data_oe,
	input wire logic flag_out,
	input wire logic flag_oe,
	input wire logic valid,
	output logic [9:0] pin_data,
	output logic pin_flag,
	output logic [9:0] cap_code,
	output logic cap_flag
);
	logic [9:0] last_reg = 10'h000;
	logic flag_last_reg = 1'b0;
	// Released lines show a toggling pattern, starting from the inverse of the last driven value
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			pin_data[i] = data_oe[i] ? data_out[i] : ~last_reg[i];
		end
		pin_flag = flag_oe ? flag_out : ~flag_last_reg;
	end
	// Remember the last levels seen on the pins
	always_ff @(posedge clk) begin
		last_reg <= pin_data;
		flag_last_reg <= pin_flag;
	end
	// Words from the wake and refill interval are discarded
	always_ff @(posedge clk) begin
		if (valid) begin
			cap_code <= pin_data;
			cap_flag <= pin_flag;
		end
	end
endmodule : arm_host_cap

// file: dv/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic [31:0] adr, wdat, rdat, r;
	logic we, cyc, ack, pdr, oen, flag, foe, valid, pflag, cflag;
	logic [1:0] mode, gsel, gout;
	logic [10:0] samp;
	logic [9:0] dout, doe, pdat, ccode;
	logic [5:0] route;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	arm_ctrl #(.WAKE_CYC(20)) dut (.CLOCK(CLOCK), .RST(RST), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_ACK_O(ack), .MODE_STRAP(mode), .REF_GEN_SELECT(gsel), .SAMPLE_IN(samp),
		.POWER_DOWN_REQUEST(pdr), .OUTPUT_DRIVE_ENABLE_N(oen), .DATA_OUT(dout), .DATA_OE(doe),
		.RANGE_EXCEEDED_FLAG(flag), .RANGE_EXCEEDED_OE(foe), .RESULT_VALID(valid),
		.REF_ROUTE(route), .GEN_OUTPUT(gout));
	arm_host_cap host (.clk(CLOCK), .data_out(dout), .data_oe(doe), .flag_out(flag),
		.flag_oe(foe), .valid(valid), .pin_data(pdat), .pin_flag(pflag), .cap_code(ccode),
		.cap_flag(cflag));
	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	initial forever #5 CLOCK = ~CLOCK;
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			end_of_test();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask : tick
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// One classic Wishbone cycle, held until ack is sampled high
	task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge CLOCK);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		chk("ack", 32'h1, {31'h0, ack});
	endtask : wb
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_codes;
		logic [10:0] s [4] = '{11'h0AA, 11'h155, 11'h200, 11'h600};
		logic [9:0] c [4] = '{10'h2AA, 10'h155, 10'h3FF, 10'h000};
		logic [3:0] f = 4'hC;
		logic [9:0] prev = 10'h2AA;
		for (int i = 0; i < 4; i++) begin
			@(posedge CLOCK);
			samp <= s[i];
			tick(3);
			chk("code before latency", {22'h0, prev}, {22'h0, dout});
			tick(1);
			chk("code", {22'h0, c[i]}, {22'h0, dout});
			chk("flag", {31'h0, f[i]}, {31'h0, flag});
			tick(1);
			chk("captured code", {22'h0, c[i]}, {22'h0, ccode});
			chk("captured flag", {31'h0, f[i]}, {31'h0, cflag});
			prev = c[i];
		end
		$display("test codes done");
	endtask : t_codes
	task t_oe;
		@(posedge CLOCK);
		oen <= 1'b1;
		tick(2);
		chk("data oe off", 32'h0, {22'h0, doe});
		chk("flag oe off", 32'h0, {31'h0, foe});
		@(posedge CLOCK);
		oen <= 1'b0;
		tick(2);
		chk("data oe on", 32'h3FF, {22'h0, doe});
		chk("flag oe on", 32'h1, {31'h0, foe});
		$display("test output enable done");
	endtask : t_oe
	task t_pd;
		int n;
		@(posedge CLOCK);
		pdr <= 1'b1;
		tick(4);
		chk("valid in power-down", 32'h0, {31'h0, valid});
		@(posedge CLOCK);
		pdr <= 1'b0;
		tick(19);
		chk("valid in wake", 32'h0, {31'h0, valid});
		n = 19;
		while (valid !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		chk("valid after wake", 32'h1, {31'h0, valid});
		$display("test power-down done");
	endtask : t_pd
	task t_bus;
		wb(1'b1, 32'h0, 32'h1);
		tick(3);
		chk("valid soft power-down", 32'h0, {31'h0, valid});
		wb(1'b0, 32'h4, 32'h0);
		chk("status power-down", 32'h1, {31'h0, r[2]});
		wb(1'b1, 32'h10, 32'h0);
		wb(1'b0, 32'h0, 32'h0);
		chk("control kept", 32'h1, {31'h0, r[0]});
		wb(1'b1, 32'h0, 32'h0);
		$display("test bus done");
	endtask : t_bus
	task t_straps;
		logic [1:0] m [3] = '{arm_pkg::ARM_MODE_GND, arm_pkg::ARM_MODE_MID, arm_pkg::ARM_MODE_SUP};
		logic [3:0] e [3] = '{4'h1, 4'hC, 4'hA};
		for (int i = 0; i < 4; i++) begin
			@(posedge CLOCK);
			gsel <= i[1:0];
			tick(3);
			chk("generator output", i, {30'h0, gout});
			chk("generator enable", {31'h0, i != 3}, {31'h0, route[0]});
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge CLOCK);
			mode <= m[i];
			tick(3);
			chk("route", {28'h0, e[i]}, {28'h0, route[5], route[4], route[3], route[1]});
		end
		chk("force driven", 32'h1, {31'h0, route[2]});
		$display("test straps done");
	endtask : t_straps
	initial begin
		{adr, wdat, we, cyc, pdr, oen} = '0;
		mode = arm_pkg::ARM_MODE_SUP;
		gsel = 2'h3;
		samp = 11'h0AA;
		repeat (10) @(posedge CLOCK);
		RST <= 1'b0;
		tick(40);
		t_codes();
		t_oe();
		t_pd();
		t_bus();
		t_straps();
		end_of_test();
	end
endmodule : testbench
